// file: rtl/dacwd_pkg.sv
package dacwd_pkg;
  // command word layout
  localparam int WORD_W      = 29;
  localparam int RW_BIT      = 28;
  localparam int CHAN_HI     = 27;
  localparam int CHAN_LO     = 24;
  localparam int KIND_HI     = 23;
  localparam int KIND_LO     = 22;
  localparam int SET_HI      = 21;
  localparam int SET_LO      = 19;
  localparam int LEVEL_HI    = 18;
  localparam int LEVEL_LO    = 16;
  localparam int DATA_HI     = 15;
  localparam int DATA_LO     = 0;
  localparam int NUM_CHAN    = 4;
  localparam int NUM_ADDR    = 64;
  localparam logic [4:0] LAST_BIT_CNT = 5'h1D;

  typedef enum logic [1:0] {
    DACWD_KIND_CTRL   = 2'b00,
    DACWD_KIND_GAIN   = 2'b01,
    DACWD_KIND_OFFSET = 2'b10,
    DACWD_KIND_INPUT  = 2'b11
  } dacwd_kind_t;

  // register sets
  localparam logic [2:0] SET_SHARED = 3'h0;
  localparam logic [2:0] SET_FORCE  = 3'h1;
  localparam logic [2:0] SET_CLAMPL = 3'h2;
  localparam logic [2:0] SET_CLAMPH = 3'h3;
  localparam logic [2:0] SET_CMPL   = 3'h4;
  localparam logic [2:0] SET_CMPH   = 3'h5;
  localparam logic [2:0] LEVEL_MAX  = 3'h5;
  localparam logic [2:0] LEVEL_CLMP = 3'h4;

  // reset values
  localparam logic [15:0] RAW_RESET   = 16'h0000;
  localparam logic [14:0] M_RESET     = 15'h7FFF;
  localparam logic [15:0] C_RESET     = 16'h8000;
  localparam logic [15:0] CAL_RESET   = 16'h0000;
  localparam logic [15:0] OFFDAC_RESET = 16'h0000;
  localparam logic [31:0] CTRL_RESET  = 32'h0000_0001;
  localparam int          M_SHIFT     = 15;

  // bus map, byte addresses
  localparam logic [7:0] ADDR_CTRL     = 8'h00;
  localparam logic [7:0] ADDR_STATUS   = 8'h04;
  localparam logic [7:0] ADDR_LASTWORD = 8'h08;
  localparam logic [7:0] ADDR_RDBK     = 8'h0C;
  localparam logic [7:0] ADDR_PEEKSEL  = 8'h10;
  localparam logic [7:0] ADDR_PEEK     = 8'h14;
  localparam int         CTRL_EN_BIT   = 0;
endpackage

// file: rtl/dacwd_sync.sv
module dacwd_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_reg;

  // first stage feeds only the second
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= '0;
      q        <= '0;
    end else begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end
endmodule

// file: rtl/dacwd_top.sv
// Summary of operation
// - bit 28 is the word's msb; data bits 15..0 sent msb first.
// - select bit 28 low writes data into the addressed register.
// - select bit 28 high starts a readback of the addressed register.
// - bits 27..24 select channels; writes apply to every selected channel, readback to the lowest one.
// - kind bits 00 route the word to system control, whatever bit 28 holds.
// - kind 01 gain, 10 offset, 11 input register.
// - bits 21..19 choose the register set.
// - bits 18..16 choose the level within the device.
// - input and offset writes store all sixteen data bits.
// - gain register is fifteen bits; data bit 0 ignored.
// - corrected code recomputed only on input register loads.
// - readback uses write decoding; reserved addresses are not used.
//
// The implementer's own choices: the AHB-Lite register port and the address map.
module dacwd_top
  import dacwd_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic      [31:0] hrdata,
  output logic             hresp,
  input  wire logic        link_sclk,
  input  wire logic        link_sync_n,
  input  wire logic        link_sdi,
  output logic             ctrl_word_valid,
  output logic      [28:0] ctrl_word,
  output logic             rdbk_valid,
  output logic      [15:0] rdbk_data,
  output logic             cal_load,
  output logic      [3:0]  cal_chan_mask,
  output logic      [5:0]  cal_addr,
  output logic      [15:0] calibrated_output_code,
  output logic      [15:0] offset_dac_code
);

  // ---------------- link domain ----------------
  logic [4:0]        bit_cnt_reg;
  logic [WORD_W-1:0] shift_reg;
  logic [WORD_W-1:0] link_word_reg;
  logic              link_tog_reg;
  wire  [WORD_W-1:0] shift_next = {shift_reg[WORD_W-2:0], link_sdi};
  wire               last_bit   = (bit_cnt_reg == LAST_BIT_CNT);

  // frame marker clears the count, so a short frame never leaks a partial word
  always_ff @(posedge link_sclk or posedge link_sync_n or negedge hresetn) begin
    if (!hresetn) begin
      bit_cnt_reg <= 5'h00;
    end else if (link_sync_n) begin
      bit_cnt_reg <= 5'h00;
    end else if (!last_bit) begin
      bit_cnt_reg <= bit_cnt_reg + 5'h01;
    end
  end

  always_ff @(posedge link_sclk or negedge hresetn) begin
    if (!hresetn) begin
      shift_reg     <= '0;
      link_word_reg <= '0;
      link_tog_reg  <= 1'b0;
    end else if (!link_sync_n && !last_bit) begin
      shift_reg <= shift_next;
      if (bit_cnt_reg == LAST_BIT_CNT - 5'h01) begin
        link_word_reg <= shift_next;
        link_tog_reg  <= ~link_tog_reg;
      end
    end
  end

  // ---------------- crossing ----------------
  // word register holds still for a whole frame after the toggle flips
  logic tog_sync;
  logic tog_seen_reg;

  dacwd_sync #(.W(1)) u_tog_sync (
    .clk   (hclk),
    .rst_n (hresetn),
    .d     (link_tog_reg),
    .q     (tog_sync)
  );

  wire word_arrive = tog_sync ^ tog_seen_reg;

  // ---------------- bus slave ----------------
  logic        ap_wr_reg;
  logic        ap_rd_reg;
  logic [7:0]  ap_addr_reg;
  logic [31:0] ctrl_reg;
  logic [7:0]  peek_sel_reg;
  logic [15:0] word_cnt_reg;
  logic [WORD_W-1:0] last_word_reg;

  wire ap_take   = hsel && htrans[1] && hready;
  wire wr_ctrl   = ap_wr_reg && (ap_addr_reg == ADDR_CTRL);
  wire wr_peek   = ap_wr_reg && (ap_addr_reg == ADDR_PEEKSEL);
  wire decode_en = ctrl_reg[CTRL_EN_BIT];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_wr_reg   <= 1'b0;
      ap_rd_reg   <= 1'b0;
      ap_addr_reg <= 8'h00;
    end else begin
      ap_wr_reg   <= ap_take && hwrite;
      ap_rd_reg   <= ap_take && !hwrite;
      ap_addr_reg <= haddr[7:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_reg     <= CTRL_RESET;
      peek_sel_reg <= 8'h00;
    end else begin
      if (wr_ctrl) ctrl_reg <= {31'h0, hwdata[CTRL_EN_BIT]};
      if (wr_peek) peek_sel_reg <= hwdata[7:0];
    end
  end

  // ---------------- command stage ----------------
  logic              cmd_fire_reg;
  logic [WORD_W-1:0] cmd_word_reg;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tog_seen_reg  <= 1'b0;
      cmd_fire_reg  <= 1'b0;
      cmd_word_reg  <= '0;
      word_cnt_reg  <= 16'h0000;
      last_word_reg <= '0;
    end else begin
      tog_seen_reg <= tog_sync;
      cmd_fire_reg <= word_arrive && decode_en;
      if (word_arrive) begin
        cmd_word_reg  <= link_word_reg;
        last_word_reg <= link_word_reg;
        word_cnt_reg  <= word_cnt_reg + 16'h0001;
      end
    end
  end

  wire              cmd_rw    = cmd_word_reg[RW_BIT];
  wire [3:0]        cmd_chan  = cmd_word_reg[CHAN_HI:CHAN_LO];
  wire dacwd_kind_t cmd_kind  = dacwd_kind_t'(cmd_word_reg[KIND_HI:KIND_LO]);
  wire [2:0]        cmd_set   = cmd_word_reg[SET_HI:SET_LO];
  wire [2:0]        cmd_level = cmd_word_reg[LEVEL_HI:LEVEL_LO];
  wire [5:0]        cmd_addr  = {cmd_set, cmd_level};
  wire [15:0]       cmd_data  = cmd_word_reg[DATA_HI:DATA_LO];

  // reserved codes are dropped rather than aliased onto a real level
  wire set_full  = (cmd_set == SET_FORCE) || (cmd_set == SET_CMPL) || (cmd_set == SET_CMPH);
  wire set_clamp = (cmd_set == SET_CLAMPL) || (cmd_set == SET_CLAMPH);
  wire addr_ok   = (set_full && cmd_level <= LEVEL_MAX)
                || (set_clamp && cmd_level >= LEVEL_CLMP && cmd_level <= LEVEL_MAX);
  wire is_shared = (cmd_addr == 6'h00) && (cmd_kind == DACWD_KIND_INPUT);
  wire is_ctrl   = cmd_fire_reg && (cmd_kind == DACWD_KIND_CTRL);
  wire dac_wr    = cmd_fire_reg && !cmd_rw && !is_ctrl && addr_ok;
  wire shared_wr = cmd_fire_reg && !cmd_rw && is_shared && (cmd_chan != 4'h0);
  wire dac_rd    = cmd_fire_reg && cmd_rw && !is_ctrl;
  wire cal_go    = dac_wr && (cmd_kind == DACWD_KIND_INPUT) && (cmd_chan != 4'h0);

  // lowest selected channel answers readback and drives the corrected value port
  wire [1:0] first_ch = cmd_chan[0] ? 2'd0 : cmd_chan[1] ? 2'd1 : cmd_chan[2] ? 2'd2 : 2'd3;

  // ---------------- register storage ----------------
  logic [15:0] raw_mem [NUM_CHAN][NUM_ADDR];
  logic [14:0] m_mem   [NUM_CHAN][NUM_ADDR];
  logic [15:0] c_mem   [NUM_CHAN][NUM_ADDR];
  logic [15:0] cal_mem [NUM_CHAN][NUM_ADDR];
  logic [15:0] offdac_reg;

  // corrected = raw * (m + 1) / 2^15 + c - 2^15, clamped to code range
  function automatic logic [15:0] calc_corrected(input logic [15:0] raw,
                                                 input logic [14:0] m,
                                                 input logic [15:0] c);
    logic [31:0] prod;
    logic [18:0] sum;
    prod = raw * ({1'b0, m} + 16'h0001);
    sum  = {2'b00, prod[31:M_SHIFT]} + {3'b000, c} - 19'h08000;
    if (sum[18])
      calc_corrected = 16'h0000;
    else if (sum[17:16] != 2'b00)
      calc_corrected = 16'hFFFF;
    else
      calc_corrected = sum[15:0];
  endfunction

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < NUM_CHAN; i++) begin
        for (int a = 0; a < NUM_ADDR; a++) begin
          raw_mem[i][a] <= RAW_RESET;
          m_mem[i][a]   <= M_RESET;
          c_mem[i][a]   <= C_RESET;
          cal_mem[i][a] <= CAL_RESET;
        end
      end
    end else if (dac_wr) begin
      for (int i = 0; i < NUM_CHAN; i++) begin
        if (cmd_chan[i]) begin
          unique case (cmd_kind)
            DACWD_KIND_GAIN:   m_mem[i][cmd_addr] <= cmd_data[15:1];
            DACWD_KIND_OFFSET: c_mem[i][cmd_addr] <= cmd_data;
            DACWD_KIND_INPUT: begin
              raw_mem[i][cmd_addr] <= cmd_data;
              cal_mem[i][cmd_addr] <= calc_corrected(cmd_data, m_mem[i][cmd_addr],
                                                     c_mem[i][cmd_addr]);
            end
            DACWD_KIND_CTRL: ;
          endcase
        end
      end
    end
  end

  // shared level has no gain or offset correction
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      offdac_reg <= OFFDAC_RESET;
    end else if (shared_wr) begin
      offdac_reg <= cmd_data;
    end
  end

  wire [15:0] rd_sel =
      is_shared                       ? offdac_reg :
      !addr_ok                        ? 16'h0000 :
      (cmd_kind == DACWD_KIND_GAIN)   ? {m_mem[first_ch][cmd_addr], 1'b0} :
      (cmd_kind == DACWD_KIND_OFFSET) ? c_mem[first_ch][cmd_addr] :
                                        raw_mem[first_ch][cmd_addr];

  // ---------------- outputs ----------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_word_valid <= 1'b0;
      ctrl_word       <= '0;
      rdbk_valid      <= 1'b0;
      rdbk_data       <= 16'h0000;
      cal_load        <= 1'b0;
      cal_chan_mask   <= 4'h0;
      cal_addr        <= 6'h00;
      calibrated_output_code <= 16'h0000;
    end else begin
      ctrl_word_valid <= is_ctrl;
      rdbk_valid      <= dac_rd;
      cal_load        <= cal_go;
      if (is_ctrl) ctrl_word <= cmd_word_reg;
      if (dac_rd) rdbk_data <= rd_sel;
      if (cal_go) begin
        cal_chan_mask <= cmd_chan;
        cal_addr      <= cmd_addr;
        calibrated_output_code <= calc_corrected(cmd_data, m_mem[first_ch][cmd_addr],
                                                 c_mem[first_ch][cmd_addr]);
      end
    end
  end

  assign offset_dac_code = offdac_reg;

  // ---------------- bus read mux ----------------
  wire [1:0] peek_ch   = peek_sel_reg[7:6];
  wire [5:0] peek_addr = peek_sel_reg[5:0];
  wire [31:0] rd_mux =
      (ap_addr_reg == ADDR_CTRL)     ? ctrl_reg :
      (ap_addr_reg == ADDR_STATUS)   ? {16'h0000, word_cnt_reg} :
      (ap_addr_reg == ADDR_LASTWORD) ? {3'b000, last_word_reg} :
      (ap_addr_reg == ADDR_RDBK)     ? {16'h0000, rdbk_data} :
      (ap_addr_reg == ADDR_PEEKSEL)  ? {24'h000000, peek_sel_reg} :
      (ap_addr_reg == ADDR_PEEK)     ? {16'h0000, cal_mem[peek_ch][peek_addr]} :
                                       32'h0000_0000;

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = ap_rd_reg ? rd_mux : 32'h0000_0000;

  // ---------------- checks ----------------
  property p_rw_write;
    @(posedge hclk) disable iff (!hresetn)
      cmd_fire_reg && !cmd_rw && cmd_kind == DACWD_KIND_OFFSET && addr_ok && cmd_chan[0]
      |=> c_mem[0][$past(cmd_addr)] == $past(cmd_data);
  endproperty
  a_rw_write: assert property (p_rw_write) else $error("offset write not stored");

  property p_readback;
    @(posedge hclk) disable iff (!hresetn)
      cmd_fire_reg && cmd_rw && cmd_kind != DACWD_KIND_CTRL |=> rdbk_valid ##1 !rdbk_valid;
  endproperty
  a_readback: assert property (p_readback) else $error("readback not one pulse");

  property p_chan_mask;
    @(posedge hclk) disable iff (!hresetn)
      cal_load |-> cal_chan_mask == $past(cmd_chan) && cal_chan_mask != 4'h0;
  endproperty
  a_chan_mask: assert property (p_chan_mask) else $error("channel mask wrong");

  property p_ctrl_route;
    @(posedge hclk) disable iff (!hresetn)
      is_ctrl |=> ctrl_word_valid && !cal_load && !rdbk_valid
                  && ctrl_word == $past(cmd_word_reg);
  endproperty
  a_ctrl_route: assert property (p_ctrl_route) else $error("control word misrouted");

  property p_addr_fields;
    @(posedge hclk) disable iff (!hresetn)
      cal_load |-> cal_addr[5:3] == $past(cmd_set) && cal_addr[2:0] == $past(cmd_level);
  endproperty
  a_addr_fields: assert property (p_addr_fields) else $error("address fields wrong");

  property p_gain_lsb;
    @(posedge hclk) disable iff (!hresetn)
      cmd_fire_reg && cmd_rw && cmd_kind == DACWD_KIND_GAIN && !is_shared
      |=> rdbk_data[0] == 1'b0;
  endproperty
  a_gain_lsb: assert property (p_gain_lsb) else $error("gain lsb not ignored");

  property p_no_recalc;
    @(posedge hclk) disable iff (!hresetn)
      cmd_fire_reg && cmd_kind != DACWD_KIND_INPUT |=> !cal_load;
  endproperty
  a_no_recalc: assert property (p_no_recalc) else $error("recalc without input load");

  property p_shared;
    @(posedge hclk) disable iff (!hresetn)
      shared_wr |=> offset_dac_code == $past(cmd_data);
  endproperty
  a_shared: assert property (p_shared) else $error("shared level not loaded");

  property p_no_chan;
    @(posedge hclk) disable iff (!hresetn)
      cmd_fire_reg && cmd_chan == 4'h0 |=> !cal_load && $stable(offset_dac_code);
  endproperty
  a_no_chan: assert property (p_no_chan) else $error("write with no channel acted");

  property p_arrive;
    @(posedge hclk) disable iff (!hresetn)
      word_arrive && decode_en |=> cmd_fire_reg ##1 !cmd_fire_reg;
  endproperty
  a_arrive: assert property (p_arrive) else $error("word not taken once");

  c_input_load: cover property (@(posedge hclk) disable iff (!hresetn) cal_load);
  c_readback:   cover property (@(posedge hclk) disable iff (!hresetn) rdbk_valid);
  c_ctrl:       cover property (@(posedge hclk) disable iff (!hresetn) ctrl_word_valid);
  c_shared:     cover property (@(posedge hclk) disable iff (!hresetn) shared_wr);

endmodule

// file: verif/dacwd_host_model.sv
module dacwd_host_model (
  output logic link_sclk,
  output logic link_sync_n,
  output logic link_sdi
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    link_sclk = 1'b0;
    link_sync_n = 1'b1;
    link_sdi = 1'b1;
  end

  // clock stands still between frames; a released data line shows the inverse
  // of its last bit so a stale value can never pass for a good one
  task automatic send(input logic [28:0] w, input int stall);
    link_sync_n = 1'b0;
    #17;
    for (int i = 28; i >= 0; i--) begin
      link_sdi = w[i];
      #40 link_sclk = 1'b1;
      #40 link_sclk = 1'b0;
      if (i == 14) begin
        #(stall);
      end
    end
    #20 link_sync_n = 1'b1;
    link_sdi = ~link_sdi;
  endtask
endmodule

// file: verif/dacwd_top_tb.sv
module dacwd_top_tb import dacwd_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;

  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic        hready;
  logic        hreadyout;
  logic [31:0] hrdata;
  logic        hresp;
  logic        link_sclk;
  logic        link_sync_n;
  logic        link_sdi;
  logic        ctrl_word_valid;
  logic [28:0] ctrl_word;
  logic        rdbk_valid;
  logic [15:0] rdbk_data;
  logic        cal_load;
  logic [3:0]  cal_chan_mask;
  logic [5:0]  cal_addr;
  logic [15:0] calibrated_output_code;
  logic [15:0] offset_dac_code;
  int          miscompares = 0;
  int          n_checks = 0;
  int          n_cal = 0;
  int          n_ctl = 0;
  int          n_rb = 0;
  int          n_words = 0;
  int          base;
  int          base_ev;
  logic [28:0] w;

  always #50 hclk = ~hclk;
  assign hready = hreadyout;

  dacwd_top uut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .link_sclk(link_sclk),
    .link_sync_n(link_sync_n), .link_sdi(link_sdi), .ctrl_word_valid(ctrl_word_valid),
    .ctrl_word(ctrl_word), .rdbk_valid(rdbk_valid), .rdbk_data(rdbk_data),
    .cal_load(cal_load), .cal_chan_mask(cal_chan_mask), .cal_addr(cal_addr),
    .calibrated_output_code(calibrated_output_code), .offset_dac_code(offset_dac_code)
  );

  dacwd_host_model host (
    .link_sclk(link_sclk),
    .link_sync_n(link_sync_n),
    .link_sdi(link_sdi)
  );

  // pulses last one cycle, so they are counted at every edge
  always @(posedge hclk) begin
    if (cal_load === 1'b1) n_cal++;
    if (ctrl_word_valid === 1'b1) n_ctl++;
    if (rdbk_valid === 1'b1) n_rb++;
  end

  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wait_rdy();
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 20);
    if (hreadyout !== 1'b1) begin
      $display("[ERR] bus ready expected 1 seen timeout");
      miscompares++;
      complete_run();
    end
  endtask

  task automatic bus(input logic wr_en, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h000000, a};
    hwrite <= wr_en;
    hsize <= 3'b010;
    wait_rdy();
    htrans <= 2'b00;
    hwdata <= wr_en ? d : 32'h0;
    wait_rdy();
    q = hrdata;
    check("hresp", {31'h0, hresp}, 32'h0);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    check(what, q, exp);
  endtask

  // result lands on the 4th hclk edge after the last link edge, so ten cycles always cover it
  task automatic xfer(input logic [28:0] word, input int stall);
    base = n_cal;
    host.send(word, stall);
    n_words++;
    repeat (10) @(posedge hclk);
  endtask

  function automatic logic [28:0] wd(logic rw, logic [3:0] ch, logic [1:0] k,
                                     logic [2:0] s, logic [2:0] l, logic [15:0] d);
    return {rw, ch, k, s, l, d};
  endfunction

  initial begin
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rdc("ctrl reset", ADDR_CTRL, 32'h1);
    rdc("status reset", ADDR_STATUS, 32'h0);
    wr(ADDR_STATUS, 32'hFFFF);
    rdc("status read only", ADDR_STATUS, 32'h0);
    rdc("unmapped", 8'h3C, 32'h0);
    $display("test registers done");
    w = wd(1'b0, 4'h1, 2'b11, SET_FORCE, 3'h0, 16'h1234);
    xfer(w, 0);
    check("cal load", n_cal, base + 1);
    check("cal mask", cal_chan_mask, 32'h1);
    check("cal addr", cal_addr, 32'h08);
    check("cal value", calibrated_output_code, 32'h1234);
    rdc("last word", ADDR_LASTWORD, {3'h0, w});
    $display("test input write done");
    xfer(wd(1'b0, 4'h1, 2'b01, SET_FORCE, 3'h0, 16'h4001), 400);
    check("no load on gain", n_cal, base);
    base_ev = n_rb;
    xfer(wd(1'b1, 4'h1, 2'b01, SET_FORCE, 3'h0, 16'h0), 0);
    check("readback pulse", n_rb, base_ev + 1);
    check("gain readback", rdbk_data, 32'h4000);
    rdc("readback reg", ADDR_RDBK, 32'h4000);
    xfer(wd(1'b0, 4'h1, 2'b11, SET_FORCE, 3'h0, 16'h1234), 0);
    check("cal with gain", calibrated_output_code, 32'h048D);
    xfer(wd(1'b0, 4'h1, 2'b10, SET_FORCE, 3'h0, 16'h8101), 0);
    check("no load on offset", n_cal, base);
    xfer(wd(1'b1, 4'h1, 2'b10, SET_FORCE, 3'h0, 16'h0), 0);
    check("offset readback", rdbk_data, 32'h8101);
    xfer(wd(1'b0, 4'h1, 2'b11, SET_FORCE, 3'h0, 16'h1234), 0);
    check("cal with offset", calibrated_output_code, 32'h058E);
    $display("test gain offset done");
    xfer(wd(1'b0, 4'hA, 2'b11, SET_CMPH, 3'h5, 16'hABCD), 0);
    check("multi mask", cal_chan_mask, 32'hA);
    check("multi addr", cal_addr, 32'h2D);
    check("multi value", calibrated_output_code, 32'hABCD);
    wr(ADDR_PEEKSEL, 32'hED);
    rdc("peek ch3", ADDR_PEEK, 32'hABCD);
    wr(ADDR_PEEKSEL, 32'h2D);
    rdc("peek ch0 untouched", ADDR_PEEK, 32'h0);
    xfer(wd(1'b0, 4'h0, 2'b11, SET_FORCE, 3'h0, 16'h7777), 0);
    check("no channel no load", n_cal, base);
    wr(ADDR_PEEKSEL, 32'h08);
    rdc("peek ch0 kept", ADDR_PEEK, 32'h058E);
    $display("test channels done");
    for (int rw = 0; rw < 2; rw++) begin
      base_ev = n_ctl;
      w = wd(rw[0], 4'h3, 2'b00, 3'h2, 3'h1, 16'h00F0);
      xfer(w, 0);
      check("ctrl pulse", n_ctl, base_ev + 1);
      check("ctrl word", {3'h0, ctrl_word}, {3'h0, w});
    end
    check("ctrl no dac load", n_cal, base);
    xfer(wd(1'b0, 4'h1, 2'b11, SET_SHARED, 3'h0, 16'h5A5A), 0);
    check("shared level", offset_dac_code, 32'h5A5A);
    xfer(wd(1'b1, 4'h1, 2'b11, SET_SHARED, 3'h0, 16'h0), 0);
    check("shared readback", rdbk_data, 32'h5A5A);
    xfer(wd(1'b0, 4'h1, 2'b11, SET_CLAMPL, 3'h0, 16'h3333), 0);
    check("reserved dropped", n_cal, base);
    base_ev = n_rb;
    xfer(wd(1'b1, 4'h1, 2'b11, SET_CLAMPL, 3'h0, 16'h0), 0);
    check("reserved read pulse", n_rb, base_ev + 1);
    check("reserved read zero", rdbk_data, 32'h0);
    $display("test control shared done");
    wr(ADDR_CTRL, 32'h0);
    w = wd(1'b0, 4'h1, 2'b11, SET_FORCE, 3'h0, 16'h2222);
    xfer(w, 0);
    check("disabled no load", n_cal, base);
    rdc("disabled last word", ADDR_LASTWORD, {3'h0, w});
    rdc("word count", ADDR_STATUS, n_words);
    wr(ADDR_CTRL, 32'h1);
    xfer(w, 0);
    check("enabled value", calibrated_output_code, 32'h0989);
    $display("test enable done");
    complete_run();
  end
endmodule
